// [logic/clocking_error_monitor.sv]
// Clocking error monitor: path admission, error levels, pin select, edge flags
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`include "clk_err_cfg.svh"

module clocking_error_monitor (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [11:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic mixDropIn,
    output logic [15:0] regRdData,
    output logic [1:0] pinOut,
    output logic irqOut
);
    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    logic [1:0] clkCtrlReg;
    clk_err_pkg::cycles_t sysBudgetReg;
    clk_err_pkg::cycles_t asyncBudgetReg;
    logic [5:0] pinFnReg [2];
    logic pathReqWr;
    clk_err_pkg::errVec_t clrMask;

    assign pathReqWr = regWr && (regAddr == `CEM_ADDR_PATH_REQ);
    assign clrMask = (regWr && (regAddr == `CEM_ADDR_ERR_FLAG)) ? regWrData[4:0] : 5'h00;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            clkCtrlReg <= `CEM_RST_CTRL;
            sysBudgetReg <= `CEM_RST_BUDGET;
            asyncBudgetReg <= `CEM_RST_BUDGET;
        end else if (ce && regWr) begin
            case (regAddr)
                `CEM_ADDR_CLK_CTRL: clkCtrlReg <= regWrData[1:0];
                `CEM_ADDR_SYS_BUDGET: sysBudgetReg <= regWrData[7:0];
                `CEM_ADDR_ASYNC_BUDGET: asyncBudgetReg <= regWrData[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pinFnReg[0] <= `CEM_RST_FN;
            pinFnReg[1] <= `CEM_RST_FN;
        end else if (ce && regWr) begin
            if (regAddr == `CEM_ADDR_PIN1_FN) pinFnReg[0] <= regWrData[5:0];
            if (regAddr == `CEM_ADDR_PIN2_FN) pinFnReg[1] <= regWrData[5:0];
        end
    end

    // ------------------------------------------------------------
    // Path admission per clock domain
    // ------------------------------------------------------------
    clk_err_pkg::pathVec_t sysActive;
    clk_err_pkg::pathVec_t asyncActive;
    clk_err_pkg::pathVec_t pathActive;
    logic sysUnder;
    logic sysOver;
    logic asyncUnder;
    logic asyncOver;

    // isochronous and serial port bits count
    domain_grant sysDomain (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .ce(ce),
        .reqWr(pathReqWr),
        .reqNew(regWrData & ~`CEM_ASYNC_PATHS),
        .clkOn(clkCtrlReg[`CEM_SYS_ENA_BIT]),
        .budget(sysBudgetReg),
        .activeReg(sysActive),
        .underReg(sysUnder),
        .overReg(sysOver)
    );

    domain_grant asyncDomain (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .ce(ce),
        .reqWr(pathReqWr),
        .reqNew(regWrData & `CEM_ASYNC_PATHS),
        .clkOn(clkCtrlReg[`CEM_ASYNC_ENA_BIT]),
        .budget(asyncBudgetReg),
        .activeReg(asyncActive),
        .underReg(asyncUnder),
        .overReg(asyncOver)
    );

    assign pathActive = sysActive | asyncActive;

    // ------------------------------------------------------------
    // Error levels
    // ------------------------------------------------------------
    clk_err_pkg::errVec_t errRawReg;
    clk_err_pkg::domState_t sysState;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) errRawReg <= 5'h00;
        else if (ce) begin
            errRawReg[`CEM_ERR_SYS_UNDER] <= sysUnder;
            errRawReg[`CEM_ERR_ASYNC_UNDER] <= asyncUnder;
            errRawReg[`CEM_ERR_MIX_DROP] <= mixDropIn;
            errRawReg[`CEM_ERR_UNDER] <= sysUnder | asyncUnder;
            errRawReg[`CEM_ERR_OVER] <= sysOver | asyncOver;
        end
    end

    // Summary of the main domain, readable beside the raw levels
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) sysState <= clk_err_pkg::DOM_IDLE;
        else if (ce) begin
            case ({sysOver, sysUnder})
                2'b00: sysState <= (sysActive != 16'h0000) ? clk_err_pkg::DOM_OK
                                                           : clk_err_pkg::DOM_IDLE;
                2'b01: sysState <= clk_err_pkg::DOM_UNDER;
                2'b10: sysState <= clk_err_pkg::DOM_OVER;
                default: sysState <= clk_err_pkg::DOM_OVER;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin function mux
    // ------------------------------------------------------------
    function automatic logic pinSelect(input logic [5:0] fn, input clk_err_pkg::errVec_t err);
        logic v;
        v = 1'b0;
        case (fn)
            `CEM_FN_SYS_UNDER: v = err[`CEM_ERR_SYS_UNDER];
            `CEM_FN_ASYNC_UNDER: v = err[`CEM_ERR_ASYNC_UNDER];
            `CEM_FN_MIX_DROP: v = err[`CEM_ERR_MIX_DROP];
            `CEM_FN_UNDER: v = err[`CEM_ERR_UNDER];
            `CEM_FN_OVER: v = err[`CEM_ERR_OVER];
            default: v = 1'b0;
        endcase
        return v;
    endfunction

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) pinOut <= 2'h0;
        else if (ce) begin
            for (int p = 0; p < 2; p++) pinOut[p] <= pinSelect(pinFnReg[p], errRawReg);
        end
    end

    // ------------------------------------------------------------
    // Interrupt flags
    // ------------------------------------------------------------
    clk_err_pkg::errVec_t flagReg;

    edge_flag_bank flags (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .ce(ce),
        .level(errRawReg),
        .clrMask(clrMask),
        .flagReg(flagReg),
        .irqReg(irqOut)
    );

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [15:0] rdNext;

    always_comb begin
        rdNext = 16'h0000;
        case (regAddr)
            `CEM_ADDR_CLK_CTRL: rdNext = {14'h0000, clkCtrlReg};
            `CEM_ADDR_SYS_BUDGET: rdNext = {8'h00, sysBudgetReg};
            `CEM_ADDR_ASYNC_BUDGET: rdNext = {8'h00, asyncBudgetReg};
            `CEM_ADDR_PATH_REQ: rdNext = pathActive;
            `CEM_ADDR_ERR_RAW: rdNext = {9'h000, sysState, errRawReg};
            `CEM_ADDR_ERR_FLAG: rdNext = {11'h000, flagReg};
            `CEM_ADDR_PIN1_FN: rdNext = {10'h000, pinFnReg[0]};
            `CEM_ADDR_PIN2_FN: rdNext = {10'h000, pinFnReg[1]};
            `CEM_ADDR_IN_STS: rdNext = {12'h000, pathActive[`CEM_IN_LSB +: 4]};
            `CEM_ADDR_OUT_STS_A: rdNext = {14'h0000, pathActive[`CEM_OUT_LSB +: 2]};
            `CEM_ADDR_OUT_STS_B: rdNext = {14'h0000, pathActive[`CEM_OUT_LSB + 2 +: 2]};
            `CEM_ADDR_RATE_STS: rdNext = {14'h0000, pathActive[`CEM_RATE_LSB +: 2]};
            `CEM_ADDR_EFFECT_STS: rdNext = {14'h0000, pathActive[`CEM_EFFECT_LSB +: 2]};
            `CEM_ADDR_MIXER_STS: rdNext = {14'h0000, pathActive[`CEM_MIX_LSB +: 2]};
            default: rdNext = 16'h0000;
        endcase
    end

    // Data stand in the cycle after a strobe taken with ce high; zero otherwise, held while ce is low
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) regRdData <= 16'h0000;
        else if (ce) regRdData <= regRd ? rdNext : 16'h0000;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence selSys_s;
        ce && pinFnReg[0] == `CEM_FN_SYS_UNDER;
    endsequence

    sequence selAsync_s;
        ce && pinFnReg[0] == `CEM_FN_ASYNC_UNDER;
    endsequence

    sequence selDrop_s;
        ce && pinFnReg[1] == `CEM_FN_MIX_DROP;
    endsequence

    pinSysUnder_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        selSys_s |=> pinOut[0] == $past(errRawReg[`CEM_ERR_SYS_UNDER]))
        else $error("pin does not show main clock underclock");
    pinAsyncUnder_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        selAsync_s |=> pinOut[0] == $past(errRawReg[`CEM_ERR_ASYNC_UNDER]))
        else $error("pin does not show async clock underclock");
    pinMixDrop_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        selDrop_s ##1 selDrop_s |=> pinOut[1] == $past(mixDropIn, 2))
        else $error("pin does not show mixer drop");
    combinedUnder_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ce |=> errRawReg[`CEM_ERR_UNDER]
            == (errRawReg[`CEM_ERR_SYS_UNDER] | errRawReg[`CEM_ERR_ASYNC_UNDER]))
        else $error("combined underclock wrong");
    overFlag_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ce && (sysOver || asyncOver) |=> errRawReg[`CEM_ERR_OVER])
        else $error("overclock not raised");
    statusRead_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ce && regRd && regAddr == `CEM_ADDR_IN_STS
            |=> regRdData[3:0] == $past(sysActive[3:0]))
        else $error("input status read wrong");

    sequence selUnder_s;
        ce && pinFnReg[1] == `CEM_FN_UNDER;
    endsequence

    sequence selOver_s;
        ce && pinFnReg[0] == `CEM_FN_OVER;
    endsequence

    pinUnder_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        selUnder_s |=> pinOut[1] == $past(errRawReg[`CEM_ERR_UNDER]))
        else $error("pin does not show combined underclock");
    pinOver_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        selOver_s |=> pinOut[0] == $past(errRawReg[`CEM_ERR_OVER]))
        else $error("pin does not show overclock");
    pinFnWrite_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ce && regWr && regAddr == `CEM_ADDR_PIN1_FN
            |=> pinFnReg[0] == $past(regWrData[5:0]))
        else $error("pin function select not written");
    noClockNoPath_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ce && pathReqWr && !clkCtrlReg[`CEM_SYS_ENA_BIT]
            |=> (sysActive & ~$past(sysActive)) == 16'h0000)
        else $error("path admitted with main clock off");
    overState_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ce && sysOver |=> sysState == clk_err_pkg::DOM_OVER)
        else $error("main domain state misses overclock");
    flagRead_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ce && regRd && regAddr == `CEM_ADDR_ERR_FLAG
            |=> regRdData == {11'h000, $past(flagReg)})
        else $error("flag read wrong");

    // Status reads must match the granted paths of the domain that owns them
    outStsRead_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ce && regRd && regAddr == `CEM_ADDR_OUT_STS_B
            |=> regRdData == {14'h0000, $past(sysActive[`CEM_OUT_LSB + 2 +: 2])})
        else $error("second output status read wrong");
    rateStsRead_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ce && regRd && regAddr == `CEM_ADDR_RATE_STS
            |=> regRdData == {14'h0000, $past(asyncActive[`CEM_RATE_LSB +: 2])})
        else $error("rate converter status read wrong");
    effectStsRead_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ce && regRd && regAddr == `CEM_ADDR_EFFECT_STS
            |=> regRdData == {14'h0000, $past(sysActive[`CEM_EFFECT_LSB +: 2])})
        else $error("effects status read wrong");
    mixStsRead_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ce && regRd && regAddr == `CEM_ADDR_MIXER_STS
            |=> regRdData == {14'h0000, $past(sysActive[`CEM_MIX_LSB +: 2])})
        else $error("mixer status read wrong");
endmodule // clocking_error_monitor

// [logic/clk_err_cfg.svh]
// Offsets, field positions, reset values and cost figures of the clocking error monitor
`ifndef CLK_ERR_CFG_SVH
`define CLK_ERR_CFG_SVH

// Register addresses
`define CEM_ADDR_CLK_CTRL 12'h0100
`define CEM_ADDR_SYS_BUDGET 12'h0101
`define CEM_ADDR_ASYNC_BUDGET 12'h0102
`define CEM_ADDR_PATH_REQ 12'h0110
`define CEM_ADDR_ERR_RAW 12'h0120
`define CEM_ADDR_ERR_FLAG 12'h0121
`define CEM_ADDR_PIN1_FN 12'h0130
`define CEM_ADDR_PIN2_FN 12'h0131
`define CEM_ADDR_IN_STS 12'h0301
`define CEM_ADDR_OUT_STS_A 12'h0401
`define CEM_ADDR_OUT_STS_B 12'h0406
`define CEM_ADDR_MIXER_STS 12'h0640
`define CEM_ADDR_EFFECT_STS 12'h0E01
`define CEM_ADDR_RATE_STS 12'h0EE1

// Clock control fields
`define CEM_SYS_ENA_BIT 0
`define CEM_ASYNC_ENA_BIT 1

// Path request fields
`define CEM_IN_LSB 0
`define CEM_OUT_LSB 4
`define CEM_RATE_LSB 8
`define CEM_EFFECT_LSB 10
`define CEM_MIX_LSB 12
`define CEM_ISO_BIT 14
`define CEM_PORT_BIT 15
`define CEM_ASYNC_PATHS 16'h0300

// Error vector positions
`define CEM_ERR_SYS_UNDER 0
`define CEM_ERR_ASYNC_UNDER 1
`define CEM_ERR_MIX_DROP 2
`define CEM_ERR_UNDER 3
`define CEM_ERR_OVER 4

// Pin function codes
`define CEM_FN_SYS_UNDER 6'h0A
`define CEM_FN_ASYNC_UNDER 6'h0B
`define CEM_FN_MIX_DROP 6'h27
`define CEM_FN_UNDER 6'h2D
`define CEM_FN_OVER 6'h2E

// Reset values
`define CEM_RST_CTRL 2'h0
`define CEM_RST_BUDGET 8'h00
`define CEM_RST_FN 6'h00

// Cycle cost per path and device limit, in processing cycles per sample
`define CEM_COST_IN 8'h04
`define CEM_COST_OUT 8'h06
`define CEM_COST_RATE 8'h08
`define CEM_COST_EFFECT 8'h0A
`define CEM_COST_MIX 8'h03
`define CEM_COST_ISO 8'h08
`define CEM_COST_PORT 8'h02
`define CEM_CYCLE_LIMIT 8'h40

`endif

// [logic/clk_err_pkg.sv]
// Types and cycle-demand arithmetic shared by the clocking error monitor
`include "clk_err_cfg.svh"

package clk_err_pkg;

    typedef logic [15:0] pathVec_t;
    typedef logic [7:0] cycles_t;
    typedef logic [4:0] errVec_t;

    typedef enum logic [1:0] {
        DOM_IDLE = 2'b00,
        DOM_OK = 2'b01,
        DOM_UNDER = 2'b10,
        DOM_OVER = 2'b11
    } domState_t;

    function automatic cycles_t costOf(input int idx);
        cycles_t c;
        c = 8'h00;
        if (idx < `CEM_OUT_LSB) c = `CEM_COST_IN;
        else if (idx < `CEM_RATE_LSB) c = `CEM_COST_OUT;
        else if (idx < `CEM_EFFECT_LSB) c = `CEM_COST_RATE;
        else if (idx < `CEM_MIX_LSB) c = `CEM_COST_EFFECT;
        else if (idx < `CEM_ISO_BIT) c = `CEM_COST_MIX;
        else if (idx == `CEM_ISO_BIT) c = `CEM_COST_ISO;
        else c = `CEM_COST_PORT;
        return c;
    endfunction

    // Total cycles needed by a set of paths; worst case fits in eight bits
    function automatic cycles_t pathDemand(input pathVec_t req);
        cycles_t sum;
        sum = 8'h00;
        for (int i = 0; i < 16; i++) begin
            if (req[i]) sum = cycles_t'(sum + costOf(i));
        end
        return sum;
    endfunction

endpackage

// [logic/domain_grant.sv]
// Per-clock-domain path admission and under/over clock levels
`timescale 1ns/10ps
`include "clk_err_cfg.svh"

module domain_grant (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic reqWr,
    input wire clk_err_pkg::pathVec_t reqNew,
    input wire logic clkOn,
    input wire clk_err_pkg::cycles_t budget,
    output clk_err_pkg::pathVec_t activeReg,
    output logic underReg,
    output logic overReg
);
    clk_err_pkg::pathVec_t cmdReg;
    clk_err_pkg::pathVec_t keepPaths;
    clk_err_pkg::cycles_t avail;
    clk_err_pkg::cycles_t trial;
    clk_err_pkg::cycles_t cmdDemand;
    logic fits;

    // No clock means no cycles at all
    assign avail = clkOn ? budget : 8'h00;
    assign keepPaths = activeReg & reqNew;
    assign trial = clk_err_pkg::pathDemand(reqNew);
    assign fits = (trial <= avail) && (trial <= `CEM_CYCLE_LIMIT);
    assign cmdDemand = clk_err_pkg::pathDemand(cmdReg);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) cmdReg <= 16'h0000;
        else if (ce && reqWr) cmdReg <= reqNew;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) activeReg <= 16'h0000;
        else if (ce && reqWr) activeReg <= fits ? reqNew : keepPaths;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            underReg <= 1'b0;
            overReg <= 1'b0;
        end else if (ce) begin
            underReg <= (cmdDemand > avail) && (cmdDemand <= `CEM_CYCLE_LIMIT);
            overReg <= cmdDemand > `CEM_CYCLE_LIMIT;
        end
    end

    rejectKeepsOff_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ce && reqWr && !fits |=> (activeReg & ~$past(activeReg)) == 16'h0000)
        else $error("refused path came up");
    runningKept_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ce && reqWr |=> (activeReg & $past(keepPaths)) == $past(keepPaths))
        else $error("running path dropped by a request");
    grantAll_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ce && reqWr && fits |=> activeReg == $past(reqNew))
        else $error("fundable request not granted");
    overNotUnder_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(underReg && overReg))
        else $error("under and over clock both set");
endmodule // domain_grant

// [logic/edge_flag_bank.sv]
// Both-edge event detection with sticky write-one-to-clear flags
`timescale 1ns/10ps

module edge_flag_bank (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    input wire clk_err_pkg::errVec_t level,
    input wire clk_err_pkg::errVec_t clrMask,
    output clk_err_pkg::errVec_t flagReg,
    output logic irqReg
);
    clk_err_pkg::errVec_t prevReg;
    clk_err_pkg::errVec_t edgeHit;

    assign edgeHit = level ^ prevReg;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) prevReg <= 5'h00;
        else if (ce) prevReg <= level;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) flagReg <= 5'h00;
        else if (ce) flagReg <= (flagReg & ~clrMask) | edgeHit;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) irqReg <= 1'b0;
        else if (ce) irqReg <= |((flagReg & ~clrMask) | edgeHit);
    end

    edgeSets_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ce && (level != prevReg) |=> (flagReg & $past(edgeHit)) == $past(edgeHit))
        else $error("edge not latched");
    flagSticky_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ce |=> (flagReg & $past(flagReg) & ~$past(clrMask))
            == ($past(flagReg) & ~$past(clrMask)))
        else $error("flag dropped without a clear");
    irqFollows_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ce |=> irqReg == (flagReg != 5'h00))
        else $error("request out of step with flags");
endmodule // edge_flag_bank

// [testbench/host_model.sv]
// Host processor model that drives the register port of the clocking error monitor
`timescale 1ns/10ps
`include "clk_err_cfg.svh"

module host_model (
    input wire logic clk_sys,
    output logic [11:0] regAddr,
    output logic [15:0] regWrData,
    output logic regWr,
    output logic regRd,
    input wire logic [15:0] regRdData
);
    initial begin
        regAddr = 12'h000;
        regWrData = 16'h0000;
        regWr = 1'b0;
        regRd = 1'b0;
    end

    // Address and data are inverted once released, so stale values are never reused
    task automatic wr(input logic [11:0] addr, input logic [15:0] data);
        @(posedge clk_sys);
        regAddr <= addr;
        regWrData <= data;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
        regAddr <= ~addr;
        regWrData <= ~data;
    endtask

    task automatic rd(input logic [11:0] addr, output logic [15:0] data);
        @(posedge clk_sys);
        regAddr <= addr;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        regAddr <= ~addr;
        #1;
        data = regRdData;
    endtask

    task automatic clocksOn(input logic [7:0] sysBudget, input logic [7:0] asyncBudget);
        wr(`CEM_ADDR_SYS_BUDGET, {8'h00, sysBudget});
        wr(`CEM_ADDR_ASYNC_BUDGET, {8'h00, asyncBudget});
        wr(`CEM_ADDR_CLK_CTRL, 16'h0003);
    endtask

    task automatic clearFlags(input logic [15:0] mask);
        wr(`CEM_ADDR_ERR_FLAG, mask);
    endtask
endmodule // host_model

// [testbench/clocking_error_monitor_tb.sv]
// Self-checking testbench of the clocking error monitor
`timescale 1ns/10ps
`include "clk_err_cfg.svh"

module clocking_error_monitor_tb;
    localparam logic [15:0] sysU = 16'h0001 << `CEM_ERR_SYS_UNDER;
    localparam logic [15:0] asyU = 16'h0001 << `CEM_ERR_ASYNC_UNDER;
    localparam logic [15:0] mixD = 16'h0001 << `CEM_ERR_MIX_DROP;
    localparam logic [15:0] undr = 16'h0001 << `CEM_ERR_UNDER;
    localparam logic [15:0] ovr = 16'h0001 << `CEM_ERR_OVER;
    localparam logic [15:0] errMask = 16'h001F;

    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic mixDropIn = 1'b0;
    logic [11:0] regAddr;
    logic [15:0] regWrData;
    logic regWr;
    logic regRd;
    logic [15:0] regRdData;
    logic [1:0] pinOut;
    logic irqOut;
    int errCount = 0;
    int totalChecks = 0;
    logic [11:0] stsAddr [6];
    logic [15:0] stsExp [6];

    always #2.5 clk_sys = ~clk_sys;

    host_model i_host (
        .clk_sys(clk_sys),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regWr(regWr),
        .regRd(regRd),
        .regRdData(regRdData)
    );

    clocking_error_monitor i_dut (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .ce(ce),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regWr(regWr),
        .regRd(regRd),
        .mixDropIn(mixDropIn),
        .regRdData(regRdData),
        .pinOut(pinOut),
        .irqOut(irqOut)
    );

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic endOfTest();
        if (errCount == 0 && totalChecks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic expectReg(input string name, input logic [11:0] addr,
                             input logic [15:0] mask, input logic [15:0] exp);
        logic [15:0] d;
        i_host.rd(addr, d);
        check(name, d & mask, exp);
    endtask

    // Pins, flags and request trail a write by three cycles
    task automatic expectPins(input logic [1:0] pins, input logic irq);
        repeat (4) @(posedge clk_sys);
        #1;
        check("pinOut", {14'h0000, pinOut}, {14'h0000, pins});
        check("irqOut", {15'h0000, irqOut}, {15'h0000, irq});
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        errCount++;
        endOfTest();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        stsAddr = '{`CEM_ADDR_IN_STS, `CEM_ADDR_OUT_STS_A, `CEM_ADDR_OUT_STS_B,
                    `CEM_ADDR_RATE_STS, `CEM_ADDR_EFFECT_STS, `CEM_ADDR_MIXER_STS};
        stsExp = '{16'h000F, 16'h0003, 16'h0000, 16'h0003, 16'h0003, 16'h0003};
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        expectReg("clkCtrl", `CEM_ADDR_CLK_CTRL, 16'hFFFF, 16'h0000);
        expectReg("unmapped", 12'h0FF, 16'hFFFF, 16'h0000);
        expectPins(2'b00, 1'b0);
        // Clocks still off: nothing can be admitted
        i_host.wr(`CEM_ADDR_PATH_REQ, 16'h0001);
        expectReg("pathOff", `CEM_ADDR_PATH_REQ, 16'hFFFF, 16'h0000);
        expectReg("rawOff", `CEM_ADDR_ERR_RAW, errMask, sysU | undr);
        expectPins(2'b00, 1'b1);
        expectReg("flagRise", `CEM_ADDR_ERR_FLAG, errMask, sysU | undr);
        i_host.clearFlags(16'h001F);
        expectReg("flagClr", `CEM_ADDR_ERR_FLAG, errMask, 16'h0000);
        expectPins(2'b00, 1'b0);
        i_host.wr(`CEM_ADDR_PATH_REQ, 16'h0000);
        // Error levels settle two cycles after the write
        @(posedge clk_sys);
        expectReg("rawIdle", `CEM_ADDR_ERR_RAW, errMask, 16'h0000);
        expectReg("flagFall", `CEM_ADDR_ERR_FLAG, errMask, sysU | undr);
        i_host.clearFlags(16'h001F);
        // Main budget 16, async budget 8
        i_host.clocksOn(8'h10, 8'h08);
        expectReg("sysBudget", `CEM_ADDR_SYS_BUDGET, 16'hFFFF, 16'h0010);
        expectReg("clkOn", `CEM_ADDR_CLK_CTRL, 16'hFFFF, 16'h0003);
        i_host.wr(`CEM_ADDR_PATH_REQ, 16'h0003);
        expectReg("pathOk", `CEM_ADDR_PATH_REQ, 16'hFFFF, 16'h0003);
        expectReg("inSts", `CEM_ADDR_IN_STS, 16'hFFFF, 16'h0003);
        // Demand 20 against 16: refused, running inputs kept
        i_host.wr(`CEM_ADDR_PATH_REQ, 16'h0033);
        expectReg("pathKeep", `CEM_ADDR_PATH_REQ, 16'hFFFF, 16'h0003);
        expectReg("rawSys", `CEM_ADDR_ERR_RAW, errMask, sysU | undr);
        i_host.wr(`CEM_ADDR_PIN1_FN, 16'h000A);
        i_host.wr(`CEM_ADDR_PIN2_FN, 16'h002D);
        expectPins(2'b11, 1'b1);
        i_host.wr(`CEM_ADDR_PIN1_FN, 16'h000B);
        expectPins(2'b10, 1'b1);
        // Isochronous converter and serial port carry cost with no status bits
        i_host.wr(`CEM_ADDR_PATH_REQ, 16'h4003);
        expectReg("pathIso", `CEM_ADDR_PATH_REQ, 16'hFFFF, 16'h4003);
        expectReg("rawFit", `CEM_ADDR_ERR_RAW, errMask, 16'h0000);
        i_host.wr(`CEM_ADDR_PATH_REQ, 16'hC003);
        expectReg("pathAif", `CEM_ADDR_PATH_REQ, 16'hFFFF, 16'h4003);
        expectReg("rawAif", `CEM_ADDR_ERR_RAW, errMask, sysU | undr);
        // Main demand 76 beyond the limit, async demand 16 against 8
        i_host.wr(`CEM_ADDR_PATH_REQ, 16'hFFFF);
        expectReg("pathOver", `CEM_ADDR_PATH_REQ, 16'hFFFF, 16'h4003);
        expectReg("rawOver", `CEM_ADDR_ERR_RAW, errMask, asyU | undr | ovr);
        expectReg("stateOver", `CEM_ADDR_ERR_RAW, 16'h0060, 16'h0060);
        i_host.wr(`CEM_ADDR_PIN1_FN, 16'h002E);
        i_host.wr(`CEM_ADDR_PIN2_FN, 16'h0027);
        expectPins(2'b01, 1'b1);
        @(posedge clk_sys);
        mixDropIn <= 1'b1;
        expectPins(2'b11, 1'b1);
        expectReg("rawMix", `CEM_ADDR_ERR_RAW, mixD, mixD);
        @(posedge clk_sys);
        mixDropIn <= 1'b0;
        i_host.wr(`CEM_ADDR_PIN2_FN, 16'h003F);
        expectPins(2'b01, 1'b1);
        // Clock enable low: a pin select write must be ignored
        @(posedge clk_sys);
        ce <= 1'b0;
        i_host.wr(`CEM_ADDR_PIN1_FN, 16'h000A);
        @(posedge clk_sys);
        ce <= 1'b1;
        expectReg("ceFreeze", `CEM_ADDR_PIN1_FN, 16'hFFFF, 16'h002E);
        // Budgets 64 and 16 carry every path but the second output pair, the isochronous converter and the serial port
        i_host.clocksOn(8'h40, 8'h10);
        i_host.wr(`CEM_ADDR_PATH_REQ, 16'h3F3F);
        expectReg("pathAll", `CEM_ADDR_PATH_REQ, 16'hFFFF, 16'h3F3F);
        for (int i = 0; i < 6; i++) begin
            expectReg("pathSts", stsAddr[i], 16'hFFFF, stsExp[i]);
        end
        expectReg("rawClear", `CEM_ADDR_ERR_RAW, errMask, 16'h0000);
        expectReg("stateOk", `CEM_ADDR_ERR_RAW, 16'h0060, 16'h0020);
        i_host.clearFlags(16'h000F);
        expectReg("flagOver", `CEM_ADDR_ERR_FLAG, errMask, ovr);
        expectPins(2'b00, 1'b1);
        i_host.clearFlags(16'h0010);
        expectPins(2'b00, 1'b0);
        endOfTest();
    end
endmodule // clocking_error_monitor_tb
